// ### core/bged_pkg.sv
// Constants shared by the binary gage edge detector.
// Assumes a 25 MHz core clock and an Avalon-MM register port.
package bged_pkg;

  // ==========================================================
  // Widths
  localparam int BGED_GRAY_W = 6;
  localparam int BGED_POS_W = 10;
  localparam int BGED_LEN_W = 3;
  localparam int BGED_CNT_W = 16;

  // ==========================================================
  // Brightness levels
  localparam logic [5:0] BGED_LVL_MIN = 6'h01;
  localparam logic [5:0] BGED_LVL_MAX = 6'h3F;
  localparam logic [5:0] BGED_PIX_WHITE = 6'h3F;
  localparam logic [5:0] BGED_PIX_BLACK = 6'h00;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] BGED_OFS_THR = 4'h0;
  localparam logic [3:0] BGED_OFS_FILT = 4'h4;
  localparam logic [3:0] BGED_OFS_TOGGLE = 4'h8;
  localparam logic [3:0] BGED_OFS_STAT = 4'hC;

  // ==========================================================
  // Field positions
  localparam int BGED_THR_LO_POS = 0;
  localparam int BGED_THR_HI_POS = 8;
  localparam int BGED_FILT_LEN_POS = 0;
  localparam int BGED_FILT_BLK_POS = 8;
  localparam int BGED_TOG_POS = 0;
  localparam int BGED_STAT_POS_POS = 0;
  localparam int BGED_STAT_CNT_POS = 16;

  // ==========================================================
  // Reset values
  localparam logic [5:0] BGED_RST_THR_LO = 6'h01;
  localparam logic [5:0] BGED_RST_THR_HI = 6'h3F;
  localparam logic [2:0] BGED_RST_LEN = 3'h0;
  localparam logic BGED_RST_FILT_BLK = 1'b0;

  // ==========================================================
  // Gage tracker states
  typedef enum logic [1:0] {
    TRK_IDLE = 2'b00,
    TRK_STABLE = 2'b01,
    TRK_RUN = 2'b10
  } bged_trk_t;

endpackage

// ### core/bged_top.sv
// Binary gage edge detector: binarize, noise filter, edge report.
// Assumes pixels and gage flags come from logic on core_clk.
//
// Summary of operation
// - Both thresholds take brightness levels 1 through 63 only.
// - Pixel in area above the upper threshold becomes black.
// - Pixel in area below the lower threshold becomes black.
// - Pixel between thresholds, bounds included, becomes white.
// - Only area pixels are binarized; others pass through as gray.
// - Noise filter acts on binary gage pixels before edge search.
// - Noise runs no longer than filter length are removed, no edge.
// - Longer noise runs stay and give leading and trailing edges.
// - Each toggle selection flips the noise colour white/black.
// - White selection filters white runs; black filters black runs.
// - Upper control top gives 63; lower control bottom gives 1.
`timescale 1ns/1ps
module bged_top (
  input wire logic core_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pixel stream in
  input wire logic pix_valid,
  input wire logic [bged_pkg::BGED_GRAY_W-1:0] pix_gray,
  input wire logic pix_aoi,
  input wire logic pix_on_gage,
  input wire logic gage_start,
  // Pixel stream out
  output logic out_valid,
  output logic [bged_pkg::BGED_GRAY_W-1:0] out_pix,
  output logic out_binary,
  // Edge report
  output logic edge_valid,
  output logic [bged_pkg::BGED_POS_W-1:0] edge_pos,
  output logic edge_to_black
);
  import bged_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [5:0] bged_clamp(input logic [5:0] v);
    bged_clamp = (v < BGED_LVL_MIN) ? BGED_LVL_MIN : v;
  endfunction

  function automatic logic bged_is_black(
    input logic [5:0] g,
    input logic [5:0] lo,
    input logic [5:0] hi
  );
    bged_is_black = (g > hi) || (g < lo);
  endfunction

  // Register decode shared by the read and write paths
  function automatic logic bged_hit(
    input logic [3:0] addr,
    input logic [3:0] ofs
  );
    bged_hit = (addr == ofs);
  endfunction

  // ==========================================================
  // Register state
  logic [5:0] thr_lo_q;
  logic [5:0] thr_hi_q;
  logic [2:0] filt_len_q;
  logic filt_blk_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic bus_req;
  logic wr_go;
  logic wr_thr;
  logic wr_filt;
  logic wr_tog;
  logic [31:0] rdata_d;
  logic [15:0] edge_cnt_q;
  logic [BGED_POS_W-1:0] last_pos_q;

  // Bus answers on the second edge of a request; writes land then
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_go = avs_write & ack_q;
  assign avs_readdata = rdata_q;
  assign wr_thr = wr_go & bged_hit(avs_address, BGED_OFS_THR);
  assign wr_filt = wr_go & bged_hit(avs_address, BGED_OFS_FILT);
  assign wr_tog = wr_go & bged_hit(avs_address, BGED_OFS_TOGGLE) &
                  avs_writedata[BGED_TOG_POS];

  // Ack drops again, so back to back requests each pay one wait
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Read data is captured on the first edge of a read, while waitrequest is still high, and held until the next read
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (bged_hit(avs_address, BGED_OFS_THR)) begin
      rdata_d[BGED_THR_LO_POS +: 6] = thr_lo_q;
      rdata_d[BGED_THR_HI_POS +: 6] = thr_hi_q;
    end else if (bged_hit(avs_address, BGED_OFS_FILT)) begin
      rdata_d[BGED_FILT_LEN_POS +: 3] = filt_len_q;
      rdata_d[BGED_FILT_BLK_POS] = filt_blk_q;
    end else if (bged_hit(avs_address, BGED_OFS_STAT)) begin
      rdata_d[BGED_STAT_POS_POS +: BGED_POS_W] = last_pos_q;
      rdata_d[BGED_STAT_CNT_POS +: 16] = edge_cnt_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // Zero would blank everything, so it is raised to the lowest level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      thr_lo_q <= BGED_RST_THR_LO;
    end else if (wr_thr) begin
      thr_lo_q <= bged_clamp(avs_writedata[BGED_THR_LO_POS +: 6]);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      thr_hi_q <= BGED_RST_THR_HI;
    end else if (wr_thr) begin
      thr_hi_q <= bged_clamp(avs_writedata[BGED_THR_HI_POS +: 6]);
    end
  end

  // Length 0 turns the filter off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      filt_len_q <= BGED_RST_LEN;
    end else if (wr_filt) begin
      filt_len_q <= avs_writedata[BGED_FILT_LEN_POS +: 3];
    end
  end

  // A field write and a toggle never meet: they use different offsets
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      filt_blk_q <= BGED_RST_FILT_BLK;
    end else if (wr_filt) begin
      filt_blk_q <= avs_writedata[BGED_FILT_BLK_POS];
    end else if (wr_tog) begin
      filt_blk_q <= ~filt_blk_q;
    end
  end

  // ==========================================================
  // Binarization stage
  logic s1_valid_q;
  logic s1_gage_q;
  logic s1_start_q;
  logic s1_black_q;

  // One compare serves both the image and the gage path
  logic pix_black;
  assign pix_black = bged_is_black(pix_gray, thr_lo_q, thr_hi_q);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_pix <= BGED_PIX_BLACK;
      out_binary <= 1'b0;
    end else begin
      out_valid <= pix_valid;
      out_binary <= pix_aoi;
      if (!pix_aoi) begin
        out_pix <= pix_gray;
      end else if (pix_black) begin
        out_pix <= BGED_PIX_BLACK;
      end else begin
        out_pix <= BGED_PIX_WHITE;
      end
    end
  end

  // Stage one keeps the gage flags in line with the colour
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_valid_q <= 1'b0;
      s1_gage_q <= 1'b0;
      s1_start_q <= 1'b0;
      s1_black_q <= 1'b0;
    end else begin
      s1_valid_q <= pix_valid;
      s1_gage_q <= pix_aoi & pix_on_gage;
      s1_start_q <= gage_start;
      s1_black_q <= pix_black;
    end
  end

  // ==========================================================
  // Noise filter and edge search along the gage
  // Only gage pixels inside the area feed this stage
  bged_trk_t trk_q;
  logic stable_q;
  logic [2:0] run_q;
  logic [BGED_POS_W-1:0] run_pos_q;
  logic [BGED_POS_W-1:0] idx_q;
  logic [BGED_POS_W-1:0] cur_idx;
  logic samp;
  logic is_noise;
  logic run_long;
  bged_trk_t trk_d;
  logic stable_d;
  logic [2:0] run_d;
  logic [BGED_POS_W-1:0] run_pos_d;
  logic emit;
  logic [BGED_POS_W-1:0] emit_pos;

  assign samp = s1_valid_q & s1_gage_q;
  assign cur_idx = s1_start_q ? '0 : idx_q + 1'b1;
  assign is_noise = (s1_black_q == filt_blk_q);
  assign run_long = ({1'b0, run_q} + 4'h1) > {1'b0, filt_len_q};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= '0;
    end else if (samp) begin
      idx_q <= cur_idx;
    end
  end

  // Next state of the tracker; a run opens only while filtering is on
  // A short run still open at the gage end is dropped
  always_comb begin
    trk_d = trk_q;
    stable_d = stable_q;
    run_d = run_q;
    run_pos_d = run_pos_q;
    emit = 1'b0;
    emit_pos = cur_idx;
    if (samp && s1_start_q) begin
      // First sample sets the reference colour, no edge
      trk_d = TRK_STABLE;
      stable_d = s1_black_q;
      run_d = 3'h0;
    end else if (samp) begin
      case (trk_q)
        TRK_STABLE: begin
          if (s1_black_q != stable_q) begin
            if (is_noise && filt_len_q != 3'h0) begin
              trk_d = TRK_RUN;
              run_d = 3'h1;
              run_pos_d = cur_idx;
            end else begin
              stable_d = s1_black_q;
              emit = 1'b1;
            end
          end
        end
        TRK_RUN: begin
          if (s1_black_q == stable_q) begin
            trk_d = TRK_STABLE;
            run_d = 3'h0;
          end else if (run_long) begin
            trk_d = TRK_STABLE;
            stable_d = s1_black_q;
            run_d = 3'h0;
            emit = 1'b1;
            emit_pos = run_pos_q;
          end else begin
            run_d = run_q + 3'h1;
          end
        end
        default: begin
          // Samples before any gage start are ignored
          trk_d = TRK_IDLE;
        end
      endcase
    end
  end

  // Tracker state moves only on gage samples
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trk_q <= TRK_IDLE;
      stable_q <= 1'b0;
    end else begin
      trk_q <= trk_d;
      stable_q <= stable_d;
    end
  end

  // A run never passes the filter length, so three bits cannot wrap
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 3'h0;
      run_pos_q <= '0;
    end else begin
      run_q <= run_d;
      run_pos_q <= run_pos_d;
    end
  end

  // Leading edge of a long run carries the index of its first pixel
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      edge_valid <= 1'b0;
      edge_pos <= '0;
      edge_to_black <= 1'b0;
    end else begin
      edge_valid <= emit;
      if (emit) begin
        edge_pos <= emit_pos;
        edge_to_black <= s1_black_q;
      end
    end
  end

  // ==========================================================
  // Edge statistics for software; count wraps silently
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      edge_cnt_q <= 16'h0000;
    end else if (samp && s1_start_q) begin
      edge_cnt_q <= 16'h0000;
    end else if (edge_valid) begin
      edge_cnt_q <= edge_cnt_q + 16'h0001;
    end
  end

  // Position stays after the pass so software may read it late
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      last_pos_q <= '0;
    end else if (edge_valid) begin
      last_pos_q <= edge_pos;
    end
  end

endmodule

// ### dv/bged_props.sv
// Checker for the bged_top register port and pixel path.
// Assumes a bind to bged_top; thresholds shadowed from bus writes.
`timescale 1ns/1ps
module bged_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pix_valid,
  input wire logic [bged_pkg::BGED_GRAY_W-1:0] pix_gray,
  input wire logic pix_aoi,
  input wire logic out_valid,
  input wire logic [bged_pkg::BGED_GRAY_W-1:0] out_pix,
  input wire logic out_binary,
  input wire logic edge_valid,
  input wire logic edge_to_black
);
  import bged_pkg::*;
  // ==========
  // Threshold shadow
  logic [5:0] lo_q;
  logic [5:0] hi_q;
  logic thr_wr;
  logic rd_done;
  assign thr_wr = avs_write && !avs_waitrequest && avs_address == BGED_OFS_THR;
  assign rd_done = avs_read && !avs_waitrequest;
  // Zero is no legal level, so it lands on the bottom one
  function automatic logic [5:0] lvl(input logic [5:0] v);
    return (v == 6'h00) ? BGED_LVL_MIN : v;
  endfunction
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lo_q <= BGED_RST_THR_LO;
      hi_q <= BGED_RST_THR_HI;
    end else if (thr_wr) begin
      lo_q <= lvl(avs_writedata[5:0]);
      hi_q <= lvl(avs_writedata[13:8]);
    end
  end
  // ==========
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_wait_first: assert property ((avs_read || avs_write) &&
    !$past(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait too long");
  a_unmapped_zero: assert property (rd_done && !(avs_address inside
    {4'h0, 4'h4, 4'h8, 4'hC}) |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_toggle_zero: assert property (
    rd_done && avs_address == BGED_OFS_TOGGLE |-> avs_readdata == 32'h0000_0000)
    else $error("toggle read not zero");
  a_thr_read: assert property (
    rd_done && avs_address == BGED_OFS_THR |-> avs_readdata[5:0] == lo_q &&
    avs_readdata[13:8] == hi_q) else $error("threshold readback");
  a_gray_pass: assert property (pix_valid && !pix_aoi |=> out_valid &&
    !out_binary && out_pix == $past(pix_gray)) else $error("gray pass");
  a_bin_class: assert property (pix_valid && pix_aoi |=> out_binary &&
    out_pix == (($past(pix_gray) > $past(hi_q) ||
    $past(pix_gray) < $past(lo_q)) ?
    BGED_PIX_BLACK : BGED_PIX_WHITE)) else $error("binary class");
  a_idle_quiet: assert property (!pix_valid |=> !out_valid)
    else $error("output without pixel");
  c_edge_black: cover property (edge_valid && edge_to_black);
  c_edge_white: cover property (edge_valid && !edge_to_black);
  c_thr_write: cover property (thr_wr);
endmodule
bind bged_top bged_props bged_props_inst (.core_clk, .nrst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .pix_valid, .pix_gray, .pix_aoi, .out_valid, .out_pix, .out_binary,
  .edge_valid, .edge_to_black);

// ### dv/bged_src.sv
// Pixel source and edge sink facing bged_top.
// Assumes the bench calls px and gap just after a clock edge.
`timescale 1ns/1ps
module bged_src (
  input wire logic core_clk,
  output logic pix_valid,
  output logic [bged_pkg::BGED_GRAY_W-1:0] pix_gray,
  output logic pix_aoi,
  output logic pix_on_gage,
  output logic gage_start,
  input wire logic edge_valid,
  input wire logic [bged_pkg::BGED_POS_W-1:0] edge_pos,
  input wire logic edge_to_black
);
  import bged_pkg::*;
  logic [10:0] eq[$];
  initial begin
    pix_valid = 1'b0;
    pix_gray = 6'h00;
    pix_aoi = 1'b0;
    pix_on_gage = 1'b0;
    gage_start = 1'b0;
  end
  task px(input logic [5:0] g, input logic a, input logic o, input logic s);
    @(posedge core_clk);
    pix_valid <= 1'b1;
    pix_gray <= g;
    pix_aoi <= a;
    pix_on_gage <= o;
    gage_start <= s;
  endtask
  task gap();
    @(posedge core_clk);
    pix_valid <= 1'b0;
    pix_on_gage <= 1'b0;
    gage_start <= 1'b0;
    // Idle data keeps moving so a stale pixel never looks valid
    pix_gray <= ~pix_gray;
  endtask
  always @(posedge core_clk) begin
    if (edge_valid === 1'b1) begin
      eq.push_back({edge_to_black, edge_pos});
    end
  end
endmodule

// ### dv/bged_top_tb.sv
// Top bench for bged_top: register accesses and gage passes.
// Assumes bged_src supplies pixels and collects edges.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
  failures++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module bged_top_tb;
  import bged_pkg::*;
  logic core_clk;
  logic nrst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest;
  logic pix_valid;
  logic [5:0] pix_gray;
  logic pix_aoi;
  logic pix_on_gage;
  logic gage_start;
  logic out_valid;
  logic [5:0] out_pix;
  logic out_binary;
  logic edge_valid;
  logic [9:0] edge_pos;
  logic edge_to_black;
  logic [5:0] lv[5] = '{6'h1A, 6'h1B, 6'h2D, 6'h2E, 6'h14};
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  bged_top bged_top_inst (.core_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pix_valid,
    .pix_gray, .pix_aoi, .pix_on_gage, .gage_start, .out_valid, .out_pix,
    .out_binary, .edge_valid, .edge_pos, .edge_to_black);
  bged_src bged_src_inst (.core_clk, .pix_valid, .pix_gray, .pix_aoi,
    .pix_on_gage, .gage_start, .edge_valid, .edge_pos, .edge_to_black);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // A hung handshake would stall forever, so cap the run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      test_done();
    end
  end
  task acc(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task gage(input logic [15:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      bged_src_inst.px(pat[i] ? 6'h1E : 6'h0A, 1'b1, 1'b1, i == 0);
    end
    repeat (6) bged_src_inst.gap();
  endtask
  task edges(input logic [10:0] e0, input logic [10:0] e1);
    `CHK("edge count", 2, bged_src_inst.eq.size())
    `CHK("first edge", e0, bged_src_inst.eq[0])
    `CHK("second edge", e1, bged_src_inst.eq[1])
    bged_src_inst.eq.delete();
  endtask
  task test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    acc(1'b0, BGED_OFS_THR, 32'h0000_0000);
    `CHK("thr reset", 32'h0000_3F01, rd)
    acc(1'b0, BGED_OFS_FILT, 32'h0000_0000);
    `CHK("filt reset", 32'h0000_0000, rd)
    acc(1'b0, 4'h2, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    acc(1'b1, BGED_OFS_THR, 32'h0000_3F00);
    acc(1'b0, BGED_OFS_THR, 32'h0000_0000);
    `CHK("thr ends", 32'h0000_3F01, rd)
    acc(1'b1, BGED_OFS_THR, 32'h0000_2D1B);
    acc(1'b0, BGED_OFS_THR, 32'h0000_0000);
    `CHK("thr set", 32'h0000_2D1B, rd)
    // Levels either side of both bounds, last one outside the area
    foreach (lv[i]) bged_src_inst.px(lv[i], i < 4, 1'b0, 1'b0);
    bged_src_inst.gap();
    acc(1'b1, BGED_OFS_FILT, 32'h0000_0003);
    gage(16'h1DE0, 15);
    edges(11'h005, 11'h409);
    acc(1'b0, BGED_OFS_STAT, 32'h0000_0000);
    `CHK("stat", 32'h0002_0009, rd)
    acc(1'b1, BGED_OFS_TOGGLE, 32'h0000_0001);
    acc(1'b0, BGED_OFS_FILT, 32'h0000_0000);
    `CHK("filt black", 32'h0000_0103, rd)
    gage(16'h308F, 14);
    edges(11'h408, 11'h00C);
    acc(1'b1, BGED_OFS_TOGGLE, 32'h0000_0001);
    acc(1'b0, BGED_OFS_FILT, 32'h0000_0000);
    `CHK("filt white", 32'h0000_0003, rd)
    acc(1'b1, BGED_OFS_FILT, 32'h0000_0000);
    gage(16'h0020, 8);
    edges(11'h005, 11'h406);
    acc(1'b1, BGED_OFS_FILT, 32'h0000_0105);
    // Reset in mid-run must bring every setting back to its start value
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    acc(1'b0, BGED_OFS_THR, 32'h0000_0000);
    `CHK("thr after reset", 32'h0000_3F01, rd)
    acc(1'b0, BGED_OFS_FILT, 32'h0000_0000);
    `CHK("filt after reset", 32'h0000_0000, rd)
    acc(1'b0, BGED_OFS_STAT, 32'h0000_0000);
    `CHK("stat after reset", 32'h0000_0000, rd)
    test_done();
  end
endmodule
